// file: src/osc_ctl_pkg.sv
// Purpose: Constants for the oscillator manual enable and frequency select block.
// Assumes: 8-bit registers reached over a plain strobe port.
// Notes:   Offsets are local choices.
package osc_ctl_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;
  localparam int          NUM_OSC       = 6;
  localparam logic [3:0]  ADDR_MANUAL   = 4'h0;
  localparam logic [3:0]  ADDR_FREQ     = 4'h1;
  localparam logic [3:0]  ADDR_ACTIVE   = 4'h2;
  localparam int          MAN_LSB       = 2;
  localparam int          MAN_MSB       = 7;
  localparam int          FRQ_MSB       = 2;
  localparam logic [5:0]  MAN_RESET     = 6'h00;
  localparam logic [2:0]  RST_CFG_1MHZ  = 3'h6;
  localparam logic [2:0]  RST_CFG_32MHZ = 3'h0;
  localparam logic [2:0]  FRQ_4MHZ      = 3'h2;
  localparam logic [2:0]  FRQ_32MHZ     = 3'h6;
  localparam logic [2:0]  FRQ_RESERVED  = 3'h7;
  localparam logic [2:0]  FRQ_RESET     = 3'h0;
  localparam logic [7:0]  READ_ZERO     = 8'h00;
  localparam logic [5:0]  MHZ_1         = 6'h01;
  localparam logic [5:0]  MHZ_2         = 6'h02;
  localparam logic [5:0]  MHZ_4         = 6'h04;
  localparam logic [5:0]  MHZ_8         = 6'h08;
  localparam logic [5:0]  MHZ_12        = 6'h0C;
  localparam logic [5:0]  MHZ_16        = 6'h10;
  localparam logic [5:0]  MHZ_32        = 6'h20;
  localparam logic [5:0]  MHZ_NONE      = 6'h00;
endpackage

// file: src/osc_freq_decode.sv
// Purpose: Registered decode of the fast oscillator frequency code to MHz.
// Assumes: Code 111 is reserved and yields zero with a flag.
// Notes:   Registered so the top outputs stay flop driven.
`timescale 1ns/10ps
`default_nettype none
module osc_freq_decode
  import osc_ctl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [2:0] code,
  output logic      [5:0] mhz_q,
  output logic            reserved_q
);
  logic [5:0] mhz_d;

  // Nominal frequency table.
  always_comb begin
    case (code)
      3'h0:    mhz_d = MHZ_1;
      3'h1:    mhz_d = MHZ_2;
      3'h2:    mhz_d = MHZ_4;
      3'h3:    mhz_d = MHZ_8;
      3'h4:    mhz_d = MHZ_12;
      3'h5:    mhz_d = MHZ_16;
      3'h6:    mhz_d = MHZ_32;
      default: mhz_d = MHZ_NONE;
    endcase
  end

  // Register the decode.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mhz_q      <= MHZ_NONE;
      reserved_q <= 1'b0;
    end else begin
      mhz_q      <= mhz_d;
      reserved_q <= (code == FRQ_RESERVED);
    end
  end
endmodule
`default_nettype wire

// file: src/osc_manual_enable_freq_select.sv
// Purpose: Manual force-on bits for six oscillators and fast oscillator frequency select.
// Assumes: Strap reset_clock_source_cfg is stable while sys_rst is high.
// Notes:   Frequency default is loaded on the first clock after reset release.
`timescale 1ns/10ps
`default_nettype none
module osc_manual_enable_freq_select
  import osc_ctl_pkg::*;
(
  input  wire logic                              clock,
  input  wire logic                              sys_rst,
  input  wire logic [osc_ctl_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [osc_ctl_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [osc_ctl_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [2:0]                        reset_clock_source_cfg,
  input  wire logic [osc_ctl_pkg::NUM_OSC-1:0]   module_osc_req,
  output logic      [osc_ctl_pkg::NUM_OSC-1:0]   osc_enable,
  output logic      [2:0]                        fast_internal_freq_sel,
  output logic      [5:0]                        fast_freq_mhz,
  output logic                                   fast_freq_reserved
);
  import osc_ctl_pkg::*;

  // Bit order: [5]=ext [4]=fast [3]=mid [2]=slow [1]=secondary [0]=converter RC.
  logic [NUM_OSC-1:0] force_q;
  logic [2:0]         freq_q;
  logic               strap_done_q;
  logic [DATA_W-1:0]  rdata_q;
  logic [NUM_OSC-1:0] enable_q;

  assign reg_rdata              = rdata_q;
  assign osc_enable             = enable_q;
  assign fast_internal_freq_sel = freq_q;

  // Manual enable register; bits 1-0 are not stored so they read zero.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      force_q <= MAN_RESET;
    end else if (reg_wr && reg_addr == ADDR_MANUAL) begin
      force_q <= reg_wdata[MAN_MSB:MAN_LSB];
    end
  end

  // The strap cannot be sampled under async reset, so it is captured on the
  // first edge after release; a software write in that same cycle wins.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      freq_q       <= FRQ_RESET;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (reg_wr && reg_addr == ADDR_FREQ) begin
        freq_q <= reg_wdata[FRQ_MSB:0];
      end else if (!strap_done_q) begin
        if (reset_clock_source_cfg == RST_CFG_1MHZ) begin
          freq_q <= FRQ_4MHZ;
        end else if (reset_clock_source_cfg == RST_CFG_32MHZ) begin
          freq_q <= FRQ_32MHZ;
        end
      end
    end
  end

  // Oscillator run enables: forced on, or on demand from any module.
  generate
    for (genvar i = 0; i < NUM_OSC; i++) begin : g_en
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          enable_q[i] <= 1'b0;
        end else begin
          enable_q[i] <= force_q[i] | module_osc_req[i];
        end
      end
    end
  endgenerate

  // Read port: data valid in the cycle after the strobe, unmapped reads zero.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= READ_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_MANUAL: rdata_q <= {force_q, 2'b00};
        ADDR_FREQ:   rdata_q <= {5'h00, freq_q};
        ADDR_ACTIVE: rdata_q <= {enable_q, 2'b00};
        default:     rdata_q <= READ_ZERO;
      endcase
    end else begin
      rdata_q <= READ_ZERO;
    end
  end

  // Frequency decode for the fast internal oscillator.
  osc_freq_decode u_dec (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .code       (freq_q),
    .mhz_q      (fast_freq_mhz),
    .reserved_q (fast_freq_reserved)
  );

  // Checks.
  a_force_wins: assert property (@(posedge clock) disable iff (sys_rst)
    $past(force_q[5]) |-> enable_q[5]) else $error("forced ext osc off");
  a_fast_force: assert property (@(posedge clock) disable iff (sys_rst)
    $past(force_q[4]) |-> enable_q[4]) else $error("forced fast osc off");
  a_mid_force: assert property (@(posedge clock) disable iff (sys_rst)
    $past(force_q[3]) |-> enable_q[3]) else $error("forced mid osc off");
  a_slow_force: assert property (@(posedge clock) disable iff (sys_rst)
    $past(force_q[2]) |-> enable_q[2]) else $error("forced slow osc off");
  a_sec_force: assert property (@(posedge clock) disable iff (sys_rst)
    $past(force_q[1]) |-> enable_q[1]) else $error("forced secondary off");
  a_rc_force: assert property (@(posedge clock) disable iff (sys_rst)
    $past(force_q[0]) |-> enable_q[0]) else $error("forced rc off");
  a_decode_32: assert property (@(posedge clock) disable iff (sys_rst)
    freq_q == FRQ_32MHZ ##1 freq_q == FRQ_32MHZ |-> fast_freq_mhz == MHZ_32)
    else $error("bad 32 MHz decode");
  a_strap_1m: assert property (@(posedge clock) disable iff (sys_rst)
    !strap_done_q && !reg_wr && reset_clock_source_cfg == RST_CFG_1MHZ
    |=> freq_q == FRQ_4MHZ) else $error("1 MHz strap default wrong");
  a_strap_32m: assert property (@(posedge clock) disable iff (sys_rst)
    !strap_done_q && !reg_wr && reset_clock_source_cfg == RST_CFG_32MHZ
    |=> freq_q == FRQ_32MHZ) else $error("32 MHz strap default wrong");
  a_idle_off: assert property (@(posedge clock) disable iff (sys_rst)
    $past(force_q == 6'h00 && module_osc_req == 6'h00) |-> enable_q == 6'h00)
    else $error("osc on without cause");
  a_unused_zero: assert property (@(posedge clock) disable iff (sys_rst)
    reg_rd && reg_addr == ADDR_MANUAL |=> reg_rdata[1:0] == 2'b00)
    else $error("unused bits not zero");

  // Named steps shared by the multi-cycle checks below.
  // A write that sets the external force bit takes two edges to reach the pin:
  // one to land in the register and one more for the run enable flop.
  sequence s_ext_force_write;
    reg_wr && reg_addr == ADDR_MANUAL && reg_wdata[MAN_MSB];
  endsequence

  // A write to the manual enable register.
  sequence s_manual_write;
    reg_wr && reg_addr == ADDR_MANUAL;
  endsequence

  // A write to the frequency select register.
  sequence s_freq_write;
    reg_wr && reg_addr == ADDR_FREQ;
  endsequence

  // A frequency code that stood for two edges, so the decode flop has caught up.
  sequence s_code_held(logic [2:0] c);
    freq_q == c ##1 freq_q == c;
  endsequence

  // A read strobe aimed at one address.
  sequence s_read_at(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence

  // Software force reaches the external oscillator enable two edges after the write.
  a_ext_force_path: assert property (@(posedge clock) disable iff (sys_rst)
    s_ext_force_write |=> ##1 enable_q[5])
    else $error("external force write did not enable the oscillator");

  // Module demand alone must also start each oscillator. The enable flops sit in
  // reset on the release edge, so demand is only trusted once the block has run.
  a_ext_demand: assert property (@(posedge clock) disable iff (sys_rst)
    $past(module_osc_req[5] && strap_done_q) |-> enable_q[5])
    else $error("external demand ignored");

  a_fast_demand: assert property (@(posedge clock) disable iff (sys_rst)
    $past(module_osc_req[4] && strap_done_q) |-> enable_q[4])
    else $error("fast demand ignored");

  a_mid_demand: assert property (@(posedge clock) disable iff (sys_rst)
    $past(module_osc_req[3] && strap_done_q) |-> enable_q[3])
    else $error("mid demand ignored");

  a_slow_demand: assert property (@(posedge clock) disable iff (sys_rst)
    $past(module_osc_req[2] && strap_done_q) |-> enable_q[2])
    else $error("slow demand ignored");

  a_sec_demand: assert property (@(posedge clock) disable iff (sys_rst)
    $past(module_osc_req[1] && strap_done_q) |-> enable_q[1])
    else $error("secondary demand ignored");

  a_rc_demand: assert property (@(posedge clock) disable iff (sys_rst)
    $past(module_osc_req[0] && strap_done_q) |-> enable_q[0])
    else $error("converter rc demand ignored");

  // The run enable is exactly force or demand, nothing else keeps it high.
  a_enable_exact: assert property (@(posedge clock) disable iff (sys_rst)
    $past(strap_done_q) |-> enable_q == $past(force_q | module_osc_req))
    else $error("run enable differs from force or demand");

  // A manual write lands whole in the force bits; bits 1-0 are dropped.
  a_manual_store: assert property (@(posedge clock) disable iff (sys_rst)
    s_manual_write |=> force_q == $past(reg_wdata[MAN_MSB:MAN_LSB]))
    else $error("manual write not stored");

  // Force bits only move on a manual write.
  a_manual_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(reg_wr && reg_addr == ADDR_MANUAL) |=> $stable(force_q))
    else $error("force bits changed without a write");

  // A frequency write lands in the code; reserved code 111 is accepted too.
  a_freq_store: assert property (@(posedge clock) disable iff (sys_rst)
    s_freq_write |=> freq_q == $past(reg_wdata[FRQ_MSB:0]))
    else $error("frequency write not stored");

  // Once the strap has been taken the code only moves on a write, so a late
  // strap change cannot retune a running oscillator.
  a_freq_hold: assert property (@(posedge clock) disable iff (sys_rst)
    strap_done_q && !(reg_wr && reg_addr == ADDR_FREQ) |=> $stable(freq_q))
    else $error("frequency code changed without a write");

  // Strap codes other than the two documented ones leave the reset code alone.
  a_strap_other: assert property (@(posedge clock) disable iff (sys_rst)
    !strap_done_q && !reg_wr && reset_clock_source_cfg != RST_CFG_1MHZ &&
    reset_clock_source_cfg != RST_CFG_32MHZ |=> freq_q == FRQ_RESET)
    else $error("other strap changed the frequency code");

  // The strap is sampled once only after each reset.
  a_strap_once: assert property (@(posedge clock) disable iff (sys_rst)
    strap_done_q |=> strap_done_q)
    else $error("strap capture armed twice");

  // Nominal frequency table, one check per code.
  a_decode_1: assert property (@(posedge clock) disable iff (sys_rst)
    s_code_held(3'h0) |-> fast_freq_mhz == MHZ_1)
    else $error("bad 1 MHz decode");

  a_decode_2: assert property (@(posedge clock) disable iff (sys_rst)
    s_code_held(3'h1) |-> fast_freq_mhz == MHZ_2)
    else $error("bad 2 MHz decode");

  a_decode_4: assert property (@(posedge clock) disable iff (sys_rst)
    s_code_held(3'h2) |-> fast_freq_mhz == MHZ_4)
    else $error("bad 4 MHz decode");

  a_decode_8: assert property (@(posedge clock) disable iff (sys_rst)
    s_code_held(3'h3) |-> fast_freq_mhz == MHZ_8)
    else $error("bad 8 MHz decode");

  a_decode_12: assert property (@(posedge clock) disable iff (sys_rst)
    s_code_held(3'h4) |-> fast_freq_mhz == MHZ_12)
    else $error("bad 12 MHz decode");

  a_decode_16: assert property (@(posedge clock) disable iff (sys_rst)
    s_code_held(3'h5) |-> fast_freq_mhz == MHZ_16)
    else $error("bad 16 MHz decode");

  // The reserved code gives no frequency and raises the flag instead.
  a_decode_rsv: assert property (@(posedge clock) disable iff (sys_rst)
    s_code_held(FRQ_RESERVED) |-> fast_freq_mhz == MHZ_NONE && fast_freq_reserved)
    else $error("reserved code not flagged");

  // The flag must drop again for every legal code.
  a_rsv_clear: assert property (@(posedge clock) disable iff (sys_rst)
    freq_q != FRQ_RESERVED ##1 1'b1 |-> !fast_freq_reserved)
    else $error("reserved flag on for a legal code");

  // Reads return the register one cycle later, with the unused bits zero.
  a_rd_manual: assert property (@(posedge clock) disable iff (sys_rst)
    s_read_at(ADDR_MANUAL) |=> reg_rdata[MAN_MSB:MAN_LSB] == $past(force_q))
    else $error("manual read wrong");

  a_rd_freq: assert property (@(posedge clock) disable iff (sys_rst)
    s_read_at(ADDR_FREQ) |=> reg_rdata == {5'h00, $past(freq_q)})
    else $error("frequency read wrong");

  a_rd_active: assert property (@(posedge clock) disable iff (sys_rst)
    s_read_at(ADDR_ACTIVE) |=> reg_rdata == {$past(enable_q), 2'b00})
    else $error("run status read wrong");

  // Unmapped addresses read zero so software sees no stale data.
  a_rd_unmapped: assert property (@(posedge clock) disable iff (sys_rst)
    reg_rd && reg_addr > ADDR_ACTIVE |=> reg_rdata == READ_ZERO)
    else $error("unmapped read not zero");

  // Read data stands for one cycle only; the bus is zero between reads.
  a_rd_idle: assert property (@(posedge clock) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == READ_ZERO)
    else $error("read data left on the bus");
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the oscillator force-on and frequency select block.
// Assumes: Read data is valid only in the cycle after the read strobe.
// Notes:   A small bench model tracks the force bits and the frequency code.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import osc_ctl_pkg::*;
  logic                clock     = 1'h0;
  logic                sys_rst   = 1'h1;
  logic [ADDR_W-1:0]   reg_addr  = 4'h0;
  logic [DATA_W-1:0]   reg_wdata = 8'h00;
  logic                reg_wr    = 1'h0;
  logic                reg_rd    = 1'h0;
  logic [2:0]          rst_cfg   = 3'h6;
  logic [NUM_OSC-1:0]  req       = 6'h00;
  logic [DATA_W-1:0]   reg_rdata;
  logic [NUM_OSC-1:0]  osc_en;
  logic [2:0]          fsel;
  logic [5:0]          mhz;
  logic                rsv;
  logic [31:0]         lfsr      = 32'h00016027;
  logic [7:0]          man_m     = 8'h00;
  logic [2:0]          frq_m     = 3'h0;
  logic [31:0]         d;
  logic [2:0]          cfgs[3]   = '{3'h6, 3'h0, 3'h3};
  int                  mhz_tab[8] = '{1, 2, 4, 8, 12, 16, 32, 0};
  int                  err_total  = 0;
  int                  num_checks = 0;
  int                  cycles     = 0;

  osc_manual_enable_freq_select i_osc_manual_enable_freq_select (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reset_clock_source_cfg(rst_cfg), .module_osc_req(req), .osc_enable(osc_en),
    .fast_internal_freq_sel(fsel), .fast_freq_mhz(mhz), .fast_freq_reserved(rsv));

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 clock = ~clock;

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'h1;
    @(posedge clock);
    reg_wr    <= 1'h0;
  endtask

  // Read data is sampled just after the edge that ends the strobe, its only valid cycle.
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clock);
    reg_rd   <= 1'h0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask

  // Four edges cover the one-cycle enable lag and the one-cycle decode lag.
  task automatic settle();
    repeat (4) @(posedge clock);
    #1;
    check("osc_enable", {2'h0, osc_en}, {2'h0, man_m[7:2] | req});
    check("freq_sel", {5'h00, fsel}, {5'h00, frq_m});
    check("freq_mhz", {2'h0, mhz}, 8'(mhz_tab[frq_m]));
    check("freq_reserved", {7'h00, rsv}, {7'h00, frq_m == 3'h7});
  endtask

  // Main sequence: reset straps, every frequency code, force bits, refused accesses.
  initial begin
    foreach (cfgs[i]) begin
      @(posedge clock);
      sys_rst <= 1'h1;
      rst_cfg <= cfgs[i];
      man_m = 8'h00;
      frq_m = (cfgs[i] == 3'h6) ? 3'h2 : (cfgs[i] == 3'h0) ? 3'h6 : 3'h0;
      repeat (2) @(posedge clock);
      sys_rst <= 1'h0;
      settle();
      rd(ADDR_MANUAL, 8'h00);
      wr(ADDR_MANUAL, 8'hFC);
      man_m = 8'hFC;
    end
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_FREQ, {5'h1F, c[2:0]});
      frq_m = c[2:0];
      settle();
      rd(ADDR_FREQ, {5'h00, frq_m});
    end
    for (int k = 0; k < 14; k++) begin
      d = (k < 6) ? (32'h00000004 << k) : next_rand();
      wr(ADDR_MANUAL, d[7:0]);
      req <= (k < 6) ? 6'h00 : d[13:8];
      man_m = d[7:0] & 8'hFC;
      settle();
      rd(ADDR_MANUAL, man_m);
      rd(ADDR_ACTIVE, {man_m[7:2] | req, 2'h0});
    end
    wr(ADDR_ACTIVE, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    rd(ADDR_ACTIVE, {man_m[7:2] | req, 2'h0});
    settle();
    close_out();
  end
endmodule
`default_nettype wire
